// >>> hw/e1ts_status.sv
// receive overhead capture, protocol timers and processor read port
`timescale 1ns/100ps

// Overview of operation
// - fas word bit 7 holds first bit
// - fas bits 6-0 hold positions two-eight
// - half-second bit toggles every 0.5 s
// - one-second bit 6 toggles each second
// - nonnormal timer sets after 100 ms
// - sync persistence sets after 10 ms
// - 400 ms crc timer toggles on expiry
// - 8 ms crc timer toggles on expiry
// - crc bit toggles each ms, resyncs
// - keep-alive after 100 ms ais
// - nfas bit 7 holds first bit
// - nfas bit 6 holds marker bit
// - nfas bit 5 holds remote alarm
// - nfas bits 4-0 hold national bits
// - mf word bits 7-4 alignment pattern
// - spare bits into bit 3, 1-0
// - mf bit 2 holds remote mf loss
module e1ts_status #(
  parameter int unsigned HALF_SEC_CYC   = e1ts_pkg::HALF_SEC_CYC,
  parameter int unsigned NONNORMAL_CYC  = e1ts_pkg::NONNORMAL_CYC,
  parameter int unsigned FS_PERSIST_CYC = e1ts_pkg::FS_PERSIST_CYC,
  parameter int unsigned CRC_LONG_CYC   = e1ts_pkg::CRC_LONG_CYC,
  parameter int unsigned CRC_SHORT_CYC  = e1ts_pkg::CRC_SHORT_CYC,
  parameter int unsigned CRC_MS_CYC     = e1ts_pkg::CRC_MS_CYC,
  parameter int unsigned KEEP_ALIVE_CYC = e1ts_pkg::KEEP_ALIVE_CYC
) (
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire e1ts_pkg::e1ts_line_t rx_line,
  input  wire e1ts_pkg::e1ts_stat_t rx_stat,
  input  wire logic                 cpu_cs_n,
  input  wire logic                 cpu_rd_n,
  input  wire logic [4:0]           cpu_addr,
  output logic [7:0]                cpu_data_out_r,
  output logic                      cpu_data_oe_n_r
);

  localparam logic [31:0] HALF_LAST  = 32'(HALF_SEC_CYC - 1);
  localparam logic [31:0] NN_LAST    = 32'(NONNORMAL_CYC - 1);
  localparam logic [31:0] FS_LAST    = 32'(FS_PERSIST_CYC - 1);
  localparam logic [31:0] LONG_LAST  = 32'(CRC_LONG_CYC - 1);
  localparam logic [31:0] SHORT_LAST = 32'(CRC_SHORT_CYC - 1);
  localparam logic [31:0] MS_LAST    = 32'(CRC_MS_CYC - 1);
  localparam logic [31:0] KA_LAST    = 32'(KEEP_ALIVE_CYC - 1);

  function automatic logic [31:0] cnt_inc(input logic [31:0] cnt);
    cnt_inc = cnt + e1ts_pkg::CNT_ONE;
  endfunction

  logic [7:0]  fas_word_r;
  logic [7:0]  nfas_word_r;
  logic [7:0]  mfas_word_r;
  logic [7:0]  shift_r;
  logic [7:0]  shift_nxt;
  logic [7:0]  bit_cnt_r;
  logic [7:0]  bit_idx;
  logic [31:0] half_cnt_r;
  logic [31:0] nn_cnt_r;
  logic [31:0] fs_cnt_r;
  logic [31:0] long_cnt_r;
  logic [31:0] short_cnt_r;
  logic [31:0] ms_cnt_r;
  logic [31:0] ka_cnt_r;
  logic        half_sec_toggle_r;
  logic        one_sec_toggle_r;
  logic        nonnormal_frame_timer_r;
  logic        frame_sync_persist_timer_r;
  logic        crc_long_timer_toggle_r;
  logic        crc_short_timer_toggle_r;
  logic        crc_align_ms_toggle_r;
  logic        keep_alive_flag_r;
  logic        half_expire;
  logic        fs_set;
  logic        fs_ok;
  logic        rd_active;
  logic [7:0]  timer_word;

  assign shift_nxt = {shift_r[6:0], rx_line.line_bit};
  assign bit_idx   = rx_line.frame_start ? 8'h00 : bit_cnt_r;
  assign fs_ok     = rx_stat.frame_sync && !rx_stat.nonnormal;
  assign fs_set    = fs_ok && !frame_sync_persist_timer_r && (fs_cnt_r == FS_LAST);
  assign rd_active = !cpu_cs_n && !cpu_rd_n;
  assign half_expire = (half_cnt_r == HALF_LAST);

  always_comb begin
    timer_word = e1ts_pkg::WORD_RESET;
    timer_word[e1ts_pkg::TSW_HALF_SEC]   = half_sec_toggle_r;
    timer_word[e1ts_pkg::TSW_ONE_SEC]    = one_sec_toggle_r;
    timer_word[e1ts_pkg::TSW_NONNORMAL]  = nonnormal_frame_timer_r;
    timer_word[e1ts_pkg::TSW_FS_PERSIST] = frame_sync_persist_timer_r;
    timer_word[e1ts_pkg::TSW_CRC_LONG]   = crc_long_timer_toggle_r;
    timer_word[e1ts_pkg::TSW_CRC_SHORT]  = crc_short_timer_toggle_r;
    timer_word[e1ts_pkg::TSW_CRC_MS]     = crc_align_ms_toggle_r;
    timer_word[e1ts_pkg::TSW_KEEP_ALIVE] = keep_alive_flag_r;
  end

  // bit position within the frame, msb-first shift
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      shift_r   <= e1ts_pkg::WORD_RESET;
      bit_cnt_r <= 8'h00;
    end else if (rx_line.bit_valid) begin
      shift_r   <= shift_nxt;
      bit_cnt_r <= bit_idx + 8'h01;
    end
  end

  // time slot 0 capture, first received bit lands in bit 7
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fas_word_r  <= e1ts_pkg::WORD_RESET;
      nfas_word_r <= e1ts_pkg::WORD_RESET;
    end else if (rx_line.bit_valid && bit_idx == e1ts_pkg::TS0_LAST_BIT) begin
      if (rx_line.fas_frame) begin
        fas_word_r  <= shift_nxt;
      end else begin
        nfas_word_r <= shift_nxt;
      end
    end
  end

  // time slot 16 of frame zero of the signalling multiframe
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mfas_word_r <= e1ts_pkg::WORD_RESET;
    end else if (rx_line.bit_valid && rx_line.mf_frame0 && bit_idx == e1ts_pkg::TS16_LAST_BIT) begin
      mfas_word_r <= shift_nxt;
    end
  end

  // half and one second toggles share one counter
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      half_cnt_r        <= e1ts_pkg::CNT_ZERO;
      half_sec_toggle_r <= 1'b0;
      one_sec_toggle_r  <= 1'b0;
    end else if (half_expire) begin
      half_cnt_r        <= e1ts_pkg::CNT_ZERO;
      half_sec_toggle_r <= !half_sec_toggle_r;
      if (half_sec_toggle_r) begin
        one_sec_toggle_r <= !one_sec_toggle_r;
      end
    end else begin
      half_cnt_r <= cnt_inc(half_cnt_r);
    end
  end

  // non-normal frame persistence
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      nn_cnt_r                <= e1ts_pkg::CNT_ZERO;
      nonnormal_frame_timer_r <= 1'b0;
    end else begin
      if (!rx_stat.nonnormal) begin
        nn_cnt_r <= e1ts_pkg::CNT_ZERO;
      end else if (nn_cnt_r != NN_LAST) begin
        nn_cnt_r <= cnt_inc(nn_cnt_r);
      end
      if (fs_set) begin
        nonnormal_frame_timer_r <= 1'b0;
      end else if (rx_stat.nonnormal && nn_cnt_r == NN_LAST) begin
        nonnormal_frame_timer_r <= 1'b1;
      end
    end
  end

  // terminal frame sync persistence
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fs_cnt_r                   <= e1ts_pkg::CNT_ZERO;
      frame_sync_persist_timer_r <= 1'b0;
    end else begin
      if (!fs_ok) begin
        fs_cnt_r <= e1ts_pkg::CNT_ZERO;
      end else if (fs_cnt_r != FS_LAST) begin
        fs_cnt_r <= cnt_inc(fs_cnt_r);
      end
      if (rx_stat.nonnormal) begin
        frame_sync_persist_timer_r <= 1'b0;
      end else if (fs_set) begin
        frame_sync_persist_timer_r <= 1'b1;
      end
    end
  end

  // crc-4 multiframe alignment timers, restarted by the framer
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      long_cnt_r              <= e1ts_pkg::CNT_ZERO;
      crc_long_timer_toggle_r <= 1'b0;
    end else if (rx_stat.crc_restart) begin
      long_cnt_r <= e1ts_pkg::CNT_ZERO;
    end else if (long_cnt_r == LONG_LAST) begin
      long_cnt_r              <= e1ts_pkg::CNT_ZERO;
      crc_long_timer_toggle_r <= !crc_long_timer_toggle_r;
    end else begin
      long_cnt_r <= cnt_inc(long_cnt_r);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      short_cnt_r              <= e1ts_pkg::CNT_ZERO;
      crc_short_timer_toggle_r <= 1'b0;
    end else if (rx_stat.crc_restart) begin
      short_cnt_r <= e1ts_pkg::CNT_ZERO;
    end else if (short_cnt_r == SHORT_LAST) begin
      short_cnt_r              <= e1ts_pkg::CNT_ZERO;
      crc_short_timer_toggle_r <= !crc_short_timer_toggle_r;
    end else begin
      short_cnt_r <= cnt_inc(short_cnt_r);
    end
  end

  // millisecond toggle, phase pulled to crc sync once aligned
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ms_cnt_r              <= e1ts_pkg::CNT_ZERO;
      crc_align_ms_toggle_r <= 1'b0;
    end else if ((rx_stat.crc_aligned && rx_stat.crc_sync) || ms_cnt_r == MS_LAST) begin
      ms_cnt_r              <= e1ts_pkg::CNT_ZERO;
      crc_align_ms_toggle_r <= !crc_align_ms_toggle_r;
    end else begin
      ms_cnt_r <= cnt_inc(ms_cnt_r);
    end
  end

  // keep-alive after persistent ais
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ka_cnt_r          <= e1ts_pkg::CNT_ZERO;
      keep_alive_flag_r <= 1'b0;
    end else if (!rx_stat.ais) begin
      ka_cnt_r          <= e1ts_pkg::CNT_ZERO;
      keep_alive_flag_r <= 1'b0;
    end else if (ka_cnt_r == KA_LAST) begin
      keep_alive_flag_r <= 1'b1;
    end else begin
      ka_cnt_r <= cnt_inc(ka_cnt_r);
    end
  end

  // read port, no side effect on any word
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cpu_data_out_r  <= e1ts_pkg::UNMAPPED_DATA;
      cpu_data_oe_n_r <= 1'b1;
    end else begin
      cpu_data_oe_n_r <= !rd_active;
      if (cpu_addr == e1ts_pkg::ADDR_FAS_WORD) begin
        cpu_data_out_r <= fas_word_r;
      end else if (cpu_addr == e1ts_pkg::ADDR_TIMER_WORD) begin
        cpu_data_out_r <= timer_word;
      end else if (cpu_addr == e1ts_pkg::ADDR_NFAS_WORD) begin
        cpu_data_out_r <= nfas_word_r;
      end else if (cpu_addr == e1ts_pkg::ADDR_MFAS_WORD) begin
        cpu_data_out_r <= mfas_word_r;
      end else begin
        cpu_data_out_r <= e1ts_pkg::UNMAPPED_DATA;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  fas_capture_a: assert property (
    rx_line.bit_valid && rx_line.fas_frame && bit_idx == e1ts_pkg::TS0_LAST_BIT
    |=> fas_word_r == $past(shift_nxt))
    else $error("fas word not captured at end of slot 0");

  nfas_capture_a: assert property (
    rx_line.bit_valid && !rx_line.fas_frame && bit_idx == e1ts_pkg::TS0_LAST_BIT
    |=> nfas_word_r == $past(shift_nxt) && $stable(fas_word_r))
    else $error("nfas word not captured at end of slot 0");

  mfas_capture_a: assert property (
    !(rx_line.bit_valid && rx_line.mf_frame0 && bit_idx == e1ts_pkg::TS16_LAST_BIT)
    |=> $stable(mfas_word_r))
    else $error("mf word changed outside slot 16 of frame zero");

  one_sec_sync_a: assert property (
    $changed(one_sec_toggle_r) |-> $changed(half_sec_toggle_r) && !half_sec_toggle_r)
    else $error("one-second toggle out of step with half-second toggle");

  half_sec_step_a: assert property (
    half_expire |=> $changed(half_sec_toggle_r) && half_cnt_r == e1ts_pkg::CNT_ZERO)
    else $error("half-second toggle missed its expiry");

  nonnormal_clear_a: assert property (
    $rose(frame_sync_persist_timer_r) |-> !nonnormal_frame_timer_r)
    else $error("nonnormal timer still high after sync persistence rose");

  persist_clear_a: assert property (
    rx_stat.nonnormal |=> !frame_sync_persist_timer_r)
    else $error("sync persistence not cleared by nonnormal frames");

  crc_long_a: assert property (
    $changed(crc_long_timer_toggle_r) |-> $past(long_cnt_r) == LONG_LAST)
    else $error("400 ms toggle changed without expiry");

  crc_short_a: assert property (
    $changed(crc_short_timer_toggle_r) |-> $past(short_cnt_r) == SHORT_LAST)
    else $error("8 ms toggle changed without expiry");

  crc_ms_sync_a: assert property (
    rx_stat.crc_aligned && rx_stat.crc_sync |=> $changed(crc_align_ms_toggle_r))
    else $error("ms toggle not aligned to crc sync");

  keep_alive_a: assert property (
    !rx_stat.ais |=> !keep_alive_flag_r)
    else $error("keep-alive high without ais");

  keep_alive_set_a: assert property (
    $rose(keep_alive_flag_r) |-> $past(ka_cnt_r) == KA_LAST && $past(rx_stat.ais))
    else $error("keep-alive set before ais persisted");

  read_quiet_a: assert property (
    rd_active && !rx_line.bit_valid |=> $stable(fas_word_r) && $stable(nfas_word_r) && $stable(mfas_word_r))
    else $error("read disturbed a captured word");

endmodule

// >>> hw/e1ts_pkg.sv
// constants, register map and carrier types of the e1 receive overhead and timer status block
package e1ts_pkg;

  // processor port
  localparam int          ADDR_W = 5;
  localparam int          DATA_W = 8;
  localparam logic [4:0]  ADDR_FAS_WORD   = 5'h11;
  localparam logic [4:0]  ADDR_TIMER_WORD = 5'h12;
  localparam logic [4:0]  ADDR_NFAS_WORD  = 5'h13;
  localparam logic [4:0]  ADDR_MFAS_WORD  = 5'h14;
  localparam logic [7:0]  WORD_RESET      = 8'h00;
  localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;

  // frame geometry: 256 bits a frame, time slot 0 and time slot 16
  localparam int          BIT_CNT_W     = 8;
  localparam logic [7:0]  TS0_LAST_BIT  = 8'h07;
  localparam logic [7:0]  TS16_LAST_BIT = 8'h87;
  localparam logic [7:0]  FAS_GOOD      = 8'h1b;

  // timer word bit positions
  localparam int TSW_HALF_SEC  = 7;
  localparam int TSW_ONE_SEC   = 6;
  localparam int TSW_NONNORMAL = 5;
  localparam int TSW_FS_PERSIST = 4;
  localparam int TSW_CRC_LONG  = 3;
  localparam int TSW_CRC_SHORT = 2;
  localparam int TSW_CRC_MS    = 1;
  localparam int TSW_KEEP_ALIVE = 0;

  // times in milliseconds and the clock rate
  localparam int unsigned CLK_KHZ       = 100000;
  localparam int unsigned HALF_SEC_MS   = 500;
  localparam int unsigned NONNORMAL_MS  = 100;
  localparam int unsigned FS_PERSIST_MS = 10;
  localparam int unsigned CRC_LONG_MS   = 400;
  localparam int unsigned CRC_SHORT_MS  = 8;
  localparam int unsigned CRC_MS_MS     = 1;
  localparam int unsigned KEEP_ALIVE_MS = 100;
  localparam int unsigned HALF_SEC_CYC   = HALF_SEC_MS * CLK_KHZ;
  localparam int unsigned NONNORMAL_CYC  = NONNORMAL_MS * CLK_KHZ;
  localparam int unsigned FS_PERSIST_CYC = FS_PERSIST_MS * CLK_KHZ;
  localparam int unsigned CRC_LONG_CYC   = CRC_LONG_MS * CLK_KHZ;
  localparam int unsigned CRC_SHORT_CYC  = CRC_SHORT_MS * CLK_KHZ;
  localparam int unsigned CRC_MS_CYC     = CRC_MS_MS * CLK_KHZ;
  localparam int unsigned KEEP_ALIVE_CYC = KEEP_ALIVE_MS * CLK_KHZ;
  localparam int          CNT_W          = 32;
  localparam logic [31:0] CNT_ZERO       = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE        = 32'h0000_0001;

  // recovered line stream, one bit per bit_valid
  typedef struct packed {
    logic bit_valid;
    logic line_bit;
    logic frame_start;
    logic fas_frame;
    logic mf_frame0;
  } e1ts_line_t;

  // framer state levels and events
  typedef struct packed {
    logic frame_sync;
    logic nonnormal;
    logic crc_aligned;
    logic crc_sync;
    logic crc_restart;
    logic ais;
  } e1ts_stat_t;

endpackage

// >>> bench/e1ts_line_model.sv
// remote line terminal model: sends whole e1 frames on the receive stream
`timescale 1ns/100ps
module e1ts_line_model (
  input  wire logic            sys_clk,
  output e1ts_pkg::e1ts_line_t rx_line
);
  initial rx_line = '0;

  // ts0 goes out msb first in slots 0-7, ts16 in slots 128-135
  task automatic send_frame(input logic [7:0] ts0, input logic [7:0] ts16, input logic fas, input logic mf0);
    for (int i = 0; i < 256; i++) begin
      rx_line.bit_valid   <= 1'b1;
      rx_line.frame_start <= (i == 0);
      rx_line.fas_frame   <= fas;
      rx_line.mf_frame0   <= mf0;
      rx_line.line_bit    <= (i < 8) ? ts0[7 - i] : (i >= 128 && i < 136) ? ts16[135 - i] : i[1];
      @(posedge sys_clk);
      #1;
    end
    rx_line.bit_valid   <= 1'b0;
    rx_line.frame_start <= 1'b0;
    // idle line shows the inverse of the last bit
    rx_line.line_bit    <= ~rx_line.line_bit;
  endtask
endmodule

// >>> bench/e1ts_status_tb.sv
// self-checking bench of the receive overhead and timer status block
`timescale 1ns/100ps
module e1ts_status_tb;
  localparam int HALF = 20, NN = 10, FS = 5, LONG = 16, SHORT = 4, MS = 3, KA = 6;
  typedef struct {
    logic       fas;
    logic       mf0;
    logic [7:0] ts0;
    logic [7:0] ts16;
    logic [4:0] addr;
    logic [7:0] exp;
  } e1ts_row_t;

  logic                 sys_clk = 1'b0;
  logic                 reset_n = 1'b0;
  e1ts_pkg::e1ts_line_t rx_line;
  e1ts_pkg::e1ts_stat_t rx_stat = '0;
  logic                 cpu_cs_n = 1'b1;
  logic                 cpu_rd_n = 1'b1;
  logic [4:0]           cpu_addr = 5'h00;
  logic [7:0]           cpu_data_out_r;
  logic                 cpu_data_oe_n_r;
  int                   num_errors = 0;
  int                   checked = 0;
  int                   cycles = 0;
  int                   n;
  logic [7:0]           d;
  logic                 oe;
  e1ts_row_t            rows [6];

  always #5 sys_clk = ~sys_clk;

  e1ts_line_model u_e1ts_line_model (.sys_clk(sys_clk), .rx_line(rx_line));

  e1ts_status #(.HALF_SEC_CYC(HALF), .NONNORMAL_CYC(NN), .FS_PERSIST_CYC(FS), .CRC_LONG_CYC(LONG),
    .CRC_SHORT_CYC(SHORT), .CRC_MS_CYC(MS), .KEEP_ALIVE_CYC(KA)) u_e1ts_status (
    .sys_clk(sys_clk), .reset_n(reset_n), .rx_line(rx_line), .rx_stat(rx_stat), .cpu_cs_n(cpu_cs_n),
    .cpu_rd_n(cpu_rd_n), .cpu_addr(cpu_addr), .cpu_data_out_r(cpu_data_out_r),
    .cpu_data_oe_n_r(cpu_data_oe_n_r));

  task automatic report_and_stop;
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_n(input string what, input int exp, input int got);
    checked++;
    if (got != exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // strobes held until the data has been taken, then released for a cycle
  task automatic read_word(input logic [4:0] a, output logic [7:0] dv, output logic oev);
    cpu_addr = a;
    cpu_cs_n = 1'b0;
    cpu_rd_n = 1'b0;
    tick(2);
    dv = cpu_data_out_r;
    oev = cpu_data_oe_n_r;
    cpu_cs_n = 1'b1;
    cpu_rd_n = 1'b1;
    tick(1);
  endtask

  task automatic wait_change(input int idx, output int cnt);
    logic v;
    v = cpu_data_out_r[idx];
    cnt = 0;
    do begin
      tick(1);
      cnt++;
    end while (cpu_data_out_r[idx] === v && cnt < 100);
  endtask

  task automatic period(input string what, input int idx, input int exp);
    int c;
    wait_change(idx, c);
    wait_change(idx, c);
    cmp_n(what, exp, c);
  endtask

  initial begin
    rows[0] = '{1'b1, 1'b0, 8'h9b, 8'h00, 5'h11, 8'h9b};
    rows[1] = '{1'b1, 1'b0, 8'h1b, 8'h00, 5'h11, 8'h1b};
    rows[2] = '{1'b0, 1'b0, 8'hd5, 8'h00, 5'h13, 8'hd5};
    rows[3] = '{1'b0, 1'b1, 8'h60, 8'h0b, 5'h14, 8'h0b};
    rows[4] = '{1'b0, 1'b1, 8'h40, 8'hf4, 5'h14, 8'hf4};
    rows[5] = '{1'b1, 1'b1, 8'h9b, 8'h2a, 5'h13, 8'h40};
    tick(3);
    reset_n = 1'b1;
    tick(1);
    cmp8("idle oe_n", 8'h01, {7'h00, cpu_data_oe_n_r});
    for (int a = 0; a < 4; a++) begin
      // timer word first, before the short test timers first toggle
      read_word(5'h11 + 5'((a + 1) % 4), d, oe);
      cmp8("reset word", 8'h00, d);
      cmp8("read oe_n", 8'h00, {7'h00, oe});
    end
    for (int r = 0; r < 6; r++) begin
      u_e1ts_line_model.send_frame(rows[r].ts0, rows[r].ts16, rows[r].fas, rows[r].mf0);
      read_word(rows[r].addr, d, oe);
      cmp8("overhead word", rows[r].exp, d);
      read_word(rows[r].addr, d, oe);
      cmp8("second read", rows[r].exp, d);
    end
    read_word(5'h1b, d, oe);
    cmp8("unmapped", 8'h00, d);
    cpu_addr = 5'h12;
    cpu_cs_n = 1'b0;
    cpu_rd_n = 1'b0;
    // let the read data switch to the timer word before watching for toggles
    tick(1);
    period("half period", 7, HALF);
    period("one period", 6, 2 * HALF);
    period("long period", 3, LONG);
    period("short period", 2, SHORT);
    period("ms period", 1, MS);
    rx_stat.nonnormal = 1'b1;
    tick(NN - 2);
    cmp8("nonnormal early", 8'h00, {7'h00, cpu_data_out_r[5]});
    tick(5);
    cmp8("nonnormal set", 8'h01, {7'h00, cpu_data_out_r[5]});
    rx_stat.nonnormal = 1'b0;
    rx_stat.frame_sync = 1'b1;
    tick(FS + 3);
    cmp8("persist set", 8'h01, {7'h00, cpu_data_out_r[4]});
    cmp8("nonnormal cleared", 8'h00, {7'h00, cpu_data_out_r[5]});
    rx_stat.nonnormal = 1'b1;
    tick(3);
    cmp8("persist cleared", 8'h00, {7'h00, cpu_data_out_r[4]});
    rx_stat.nonnormal = 1'b0;
    rx_stat.ais = 1'b1;
    tick(KA - 1);
    cmp8("keep alive early", 8'h00, {7'h00, cpu_data_out_r[0]});
    tick(5);
    cmp8("keep alive set", 8'h01, {7'h00, cpu_data_out_r[0]});
    rx_stat.ais = 1'b0;
    tick(3);
    cmp8("keep alive clear", 8'h00, {7'h00, cpu_data_out_r[0]});
    rx_stat.crc_aligned = 1'b1;
    wait_change(1, n);
    rx_stat.crc_sync = 1'b1;
    tick(1);
    rx_stat.crc_sync = 1'b0;
    wait_change(1, n);
    cmp_n("ms sync lag", 1, int'(n <= 1));
    wait_change(1, n);
    cmp_n("ms after sync", MS, n);
    wait_change(2, n);
    tick(2);
    rx_stat.crc_restart = 1'b1;
    tick(1);
    rx_stat.crc_restart = 1'b0;
    wait_change(2, n);
    cmp_n("short restart", 1, int'(n >= 3));
    cpu_cs_n = 1'b1;
    cpu_rd_n = 1'b1;
    tick(3);
    cmp8("released oe_n", 8'h01, {7'h00, cpu_data_oe_n_r});
    reset_n = 1'b0;
    tick(3);
    reset_n = 1'b1;
    tick(1);
    read_word(5'h14, d, oe);
    cmp8("word after reset", 8'h00, d);
    read_word(5'h11, d, oe);
    cmp8("fas after reset", 8'h00, d);
    report_and_stop();
  end
endmodule
